// ===== logic/blm_monitor.v
// second brightness limit monitor: comparator, delays, sending
// assumes all inputs come from logic on i_core_clk
`timescale 1ns/1ps
`default_nettype none
`include "blm_map.vh"

module blm_monitor #(
  parameter integer P_CYC_PER_S = `BLM_SEC_NS / `BLM_CLK_NS
) (
  // clock and reset
  input  wire         i_core_clk,
  input  wire         i_rst,
  // enables
  input  wire         i_chan_en,
  input  wire         i_lim1_en,
  input  wire         i_lim2_en,
  // measured brightness, klx
  input  wire [15:0]  i_brightness,
  // configuration
  input  wire [4:0]   i_thr_sel,
  input  wire [3:0]   i_hys_sel,
  input  wire [3:0]   i_act_mode,
  input  wire [1:0]   i_ext_mode,
  input  wire [3:0]   i_on_dly_sel,
  input  wire [3:0]   i_off_dly_sel,
  input  wire         i_send_chg,
  input  wire [6:0]   i_cyc_sel,
  input  wire         i_download,
  // external threshold objects
  input  wire         i_ext16_wr,
  input  wire [15:0]  i_ext16_val,
  input  wire         i_ext8_wr,
  input  wire [7:0]   i_ext8_val,
  // limit object, telegram and status outputs
  output reg          o_limit_obj,
  output reg          o_tx_valid,
  output reg          o_tx_value,
  output wire         o_active,
  output reg  [15:0]  o_threshold_level
);

  // ----------------------------------------
  // decoding functions
  // ----------------------------------------
  function [15:0] thr_klx;
    input [4:0] sel;
    begin
      if (sel == 5'h00) begin
        thr_klx = `BLM_THR_MIN;
      end else if (sel > `BLM_THR_SEL_MAX) begin
        thr_klx = `BLM_THR_STEP * {11'h000, `BLM_THR_SEL_MAX};
      end else begin
        thr_klx = `BLM_THR_STEP * {11'h000, sel};
      end
    end
  endfunction

  function [7:0] hys_klx;
    input [3:0] sel;
    begin
      if (sel <= `BLM_HYS_FINE) begin
        hys_klx = {4'h0, sel};
      end else begin
        hys_klx = `BLM_HYS_STEP * {4'h0, sel - `BLM_HYS_FINE};
      end
    end
  endfunction

  function [`BLM_SEC_W-1:0] dly_s;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    dly_s = {`BLM_SEC_W{1'b0}};
        4'h1:    dly_s = `BLM_D_1S;
        4'h2:    dly_s = `BLM_D_3S;
        4'h3:    dly_s = `BLM_D_5S;
        4'h4:    dly_s = `BLM_D_10S;
        4'h5:    dly_s = `BLM_D_15S;
        4'h6:    dly_s = `BLM_D_30S;
        4'h7:    dly_s = `BLM_D_1M;
        4'h8:    dly_s = `BLM_D_3M;
        4'h9:    dly_s = `BLM_D_5M;
        4'hA:    dly_s = `BLM_D_10M;
        4'hB:    dly_s = `BLM_D_15M;
        4'hC:    dly_s = `BLM_D_30M;
        default: dly_s = `BLM_D_60M;
      endcase
    end
  endfunction

  // {falling, value on crossing, crossing sends, return sends}
  function [3:0] mode_bits;
    input [3:0] m;
    begin
      case (m)
        4'h0:    mode_bits = 4'h7;
        4'h1:    mode_bits = 4'h3;
        4'h2:    mode_bits = 4'hF;
        4'h3:    mode_bits = 4'hB;
        4'h4:    mode_bits = 4'h6;
        4'h5:    mode_bits = 4'h2;
        4'h6:    mode_bits = 4'hE;
        4'h7:    mode_bits = 4'hA;
        4'h8:    mode_bits = 4'h5;
        4'h9:    mode_bits = 4'h1;
        4'hA:    mode_bits = 4'hD;
        default: mode_bits = 4'h9;
      endcase
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam integer L_PS_MAX_I = P_CYC_PER_S - 1;
  localparam [25:0]  L_PS_MAX   = L_PS_MAX_I[25:0];

  reg  [25:0]           ps_cnt;
  reg                   sec_tick;
  reg  [15:0]           ext_val;
  reg                   ext_valid;
  reg                   cond;
  reg                   acc_cond;
  reg                   dly_armed;
  reg                   next_cond;
  reg                   dly_start;
  reg                   dly_stop;
  reg                   accept_now;
  reg  [`BLM_SEC_W-1:0] dly_len;
  wire [3:0]            mb;
  wire [15:0]           thr;
  wire [7:0]            hys;
  wire [16:0]           thr_hi;
  wire [15:0]           thr_lo;
  wire                  raw_obj;
  wire                  acc_obj;
  wire                  dly_done;
  wire                  dly_busy;
  wire                  cyc_done;
  wire                  cyc_busy;
  wire                  cyc_start;
  wire [`BLM_SEC_W-1:0] cyc_len;
  wire                  dly_fin;
  wire                  new_cond;
  wire                  chg_evt;
  wire                  tx_ok_new;
  wire                  tx_ok_old;

  // ----------------------------------------
  // one-second enable
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ps_cnt   <= 26'h0000000;
      sec_tick <= 1'b0;
    end else if (ps_cnt == L_PS_MAX) begin
      ps_cnt   <= 26'h0000000;
      sec_tick <= 1'b1;
    end else begin
      ps_cnt   <= ps_cnt + 26'h0000001;
      sec_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // threshold selection
  // ----------------------------------------
  assign o_active = i_chan_en & i_lim1_en & i_lim2_en;
  assign mb       = mode_bits(i_act_mode);

  // a write in the download cycle still counts: set beats clear
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ext_val   <= 16'h0000;
      ext_valid <= 1'b0;
    end else if (i_ext_mode == `BLM_EXT_16 && i_ext16_wr) begin
      ext_val   <= i_ext16_val;
      ext_valid <= 1'b1;
    end else if (i_ext_mode == `BLM_EXT_8 && i_ext8_wr) begin
      ext_val   <= {8'h00, i_ext8_val};
      ext_valid <= 1'b1;
    end else if (i_download) begin
      ext_valid <= 1'b0;
    end
  end

  assign thr = (ext_valid && i_ext_mode != `BLM_EXT_NONE) ?
               ext_val : thr_klx(i_thr_sel);
  assign hys = hys_klx(i_hys_sel);

  assign thr_hi = {1'b0, thr} + {9'h000, hys};
  // saturate so a large hysteresis cannot wrap below zero
  assign thr_lo = (thr > {8'h00, hys}) ?
                  thr - {8'h00, hys} : 16'h0000;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_threshold_level <= 16'h0000;
    end else begin
      o_threshold_level <= thr;
    end
  end

  // ----------------------------------------
  // comparator with hysteresis
  // ----------------------------------------
  always @* begin
    next_cond = cond;
    if (!mb[`BLM_MB_FALL]) begin
      if (i_brightness > thr) begin
        next_cond = 1'b1;
      end else if (i_brightness < thr_lo) begin
        next_cond = 1'b0;
      end
    end else begin
      if (i_brightness < thr) begin
        next_cond = 1'b1;
      end else if ({1'b0, i_brightness} > thr_hi) begin
        next_cond = 1'b0;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst || !o_active) begin
      cond <= 1'b0;
    end else begin
      cond <= next_cond;
    end
  end

  // ----------------------------------------
  // switch-on / switch-off delay
  // ----------------------------------------
  assign raw_obj = cond ? mb[`BLM_MB_XVAL] : ~mb[`BLM_MB_XVAL];
  assign acc_obj = acc_cond ? mb[`BLM_MB_XVAL] : ~mb[`BLM_MB_XVAL];

  always @* begin
    dly_len    = raw_obj ? dly_s(i_on_dly_sel) : dly_s(i_off_dly_sel);
    dly_start  = 1'b0;
    dly_stop   = 1'b0;
    accept_now = 1'b0;
    if (cond == acc_cond) begin
      dly_stop = dly_armed; // change withdrawn before expiry
    end else if (!dly_armed) begin
      if (dly_len == {`BLM_SEC_W{1'b0}}) begin
        accept_now = 1'b1;
      end else begin
        dly_start = 1'b1;
      end
    end
  end

  blm_timer u_dly (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_tick     (sec_tick),
    .i_start    (dly_start),
    .i_stop     (dly_stop),
    .i_len      (dly_len),
    .o_done     (dly_done),
    .o_busy     (dly_busy)
  );

  assign dly_fin = dly_armed & dly_done & (cond != acc_cond);

  // acc_cond moves only at expiry or at once for a zero delay, so cyclic sends repeat the old state
  always @(posedge i_core_clk) begin
    if (i_rst || !o_active) begin
      acc_cond  <= 1'b0;
      dly_armed <= 1'b0;
    end else begin
      if (accept_now || dly_fin) begin
        acc_cond <= cond;
      end
      if (dly_start) begin
        dly_armed <= 1'b1;
      end else if (dly_stop || dly_fin || !dly_busy) begin
        dly_armed <= dly_armed & dly_busy & ~dly_stop & ~dly_fin;
      end
    end
  end

  // ----------------------------------------
  // cyclic schedule
  // ----------------------------------------
  assign cyc_len = {5'h00, i_cyc_sel} *
                   `BLM_CYC_UNIT_S;
  // auto re-arm: a zero setting never loads, so never expires
  assign cyc_start = o_active & ~cyc_busy &
                     (i_cyc_sel != 7'h00);

  blm_timer u_cyc (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_tick     (sec_tick),
    .i_start    (cyc_start),
    .i_stop     (~o_active | (i_cyc_sel == 7'h00)),
    .i_len      (cyc_len),
    .o_done     (cyc_done),
    .o_busy     (cyc_busy)
  );

  // ----------------------------------------
  // telegram output
  // ----------------------------------------
  assign new_cond  = cond;
  assign chg_evt   = accept_now | dly_fin;
  assign tx_ok_new = new_cond ? mb[`BLM_MB_XTX] : mb[`BLM_MB_RTX];
  assign tx_ok_old = acc_cond ? mb[`BLM_MB_XTX] : mb[`BLM_MB_RTX];

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_valid  <= 1'b0;
      o_tx_value  <= 1'b0;
      o_limit_obj <= 1'b0;
    end else begin
      o_tx_valid  <= 1'b0;
      o_limit_obj <= acc_obj;
      if (chg_evt) begin
        o_limit_obj <= raw_obj;
        // a cyclic slot landing on a change still sends the new value
        if ((i_send_chg || cyc_done) && tx_ok_new) begin
          o_tx_valid <= 1'b1;
          o_tx_value <= raw_obj;
        end
      end else if (cyc_done && tx_ok_old) begin
        o_tx_valid <= 1'b1;
        o_tx_value <= acc_obj;
      end
    end
  end

endmodule

`default_nettype wire

// ===== pkg/blm_map.vh
// constants for the second brightness limit monitor
// assumes brightness and thresholds are whole klx on one clock
`ifndef BLM_MAP_VH
`define BLM_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define BLM_CLK_NS      20
`define BLM_SEC_NS      1000000000
`define BLM_CYC_UNIT_S  12'h00A
`define BLM_SEC_W       12

// ----------------------------------------
// threshold and hysteresis tables
// ----------------------------------------
`define BLM_THR_MIN     16'h0003
`define BLM_THR_STEP    16'h0005
`define BLM_THR_SEL_MAX 5'h15
`define BLM_HYS_FINE    4'h5
`define BLM_HYS_STEP    8'h0A

// ----------------------------------------
// external threshold sources
// ----------------------------------------
`define BLM_EXT_NONE    2'h0
`define BLM_EXT_16      2'h1
`define BLM_EXT_8       2'h2

// ----------------------------------------
// activation mode field positions
// ----------------------------------------
`define BLM_MB_FALL     3
`define BLM_MB_XVAL     2
`define BLM_MB_XTX      1
`define BLM_MB_RTX      0
`define BLM_MODE_MAX    4'hB

// ----------------------------------------
// delay durations in seconds
// ----------------------------------------
`define BLM_D_1S        12'h001
`define BLM_D_3S        12'h003
`define BLM_D_5S        12'h005
`define BLM_D_10S       12'h00A
`define BLM_D_15S       12'h00F
`define BLM_D_30S       12'h01E
`define BLM_D_1M        12'h03C
`define BLM_D_3M        12'h0B4
`define BLM_D_5M        12'h12C
`define BLM_D_10M       12'h258
`define BLM_D_15M       12'h384
`define BLM_D_30M       12'h708
`define BLM_D_60M       12'hE10

`endif

// ===== logic/blm_timer.v
// second-granular down counter with one-cycle expiry pulse
// assumes i_tick is a one-cycle pulse once per second
`timescale 1ns/1ps
`default_nettype none
`include "blm_map.vh"

module blm_timer (
  // clock and reset
  input  wire                   i_core_clk,
  input  wire                   i_rst,
  // control
  input  wire                   i_tick,
  input  wire                   i_start,
  input  wire                   i_stop,
  input  wire [`BLM_SEC_W-1:0]  i_len,
  // status
  output reg                    o_done,
  output wire                   o_busy
);

  reg [`BLM_SEC_W-1:0] cnt;

  assign o_busy = (cnt != {`BLM_SEC_W{1'b0}});

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  // first tick may come early: up to one second short
  always @(posedge i_core_clk) begin
    if (i_rst || i_stop) begin
      cnt    <= {`BLM_SEC_W{1'b0}};
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt <= i_len;
      end else if (i_tick && o_busy) begin
        cnt <= cnt - {{(`BLM_SEC_W-1){1'b0}}, 1'b1};
        if (cnt == {{(`BLM_SEC_W-1){1'b0}}, 1'b1}) begin
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== testbench/blm_chk.sv
// port checks for the limit monitor
// assumes one clock and a sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module blm_chk (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // inputs
  input wire logic        i_chan_en,
  input wire logic        i_lim1_en,
  input wire logic        i_lim2_en,
  input wire logic [15:0] i_brightness,
  input wire logic [4:0]  i_thr_sel,
  input wire logic [3:0]  i_act_mode,
  input wire logic [1:0]  i_ext_mode,
  input wire logic [3:0]  i_on_dly_sel,
  input wire logic        i_send_chg,
  input wire logic [6:0]  i_cyc_sel,
  input wire logic        i_download,
  input wire logic        i_ext16_wr,
  input wire logic [15:0] i_ext16_val,
  input wire logic        i_ext8_wr,
  input wire logic [7:0]  i_ext8_val,
  // outputs
  input wire logic        o_limit_obj,
  input wire logic        o_tx_valid,
  input wire logic        o_tx_value,
  input wire logic        o_active,
  input wire logic [15:0] o_threshold_level
);
  default clocking dc @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  function automatic logic [15:0] cfg_thr(input logic [4:0] s);
    if (s == 5'h00) return 16'h0003;
    if (s > 5'h15) return 16'h0069;
    return 16'h0005 * s;
  endfunction
  a_active_gate: assert property (
    o_active == (i_chan_en && i_lim1_en && i_lim2_en))
    else $error("active flag wrong");
  a_thr_table: assert property (
    (i_ext_mode == 2'h0 && $stable(i_thr_sel))[*4]
    |-> o_threshold_level == cfg_thr(i_thr_sel))
    else $error("configured threshold wrong");
  a_ext16_take: assert property (
    i_ext16_wr && i_ext_mode == 2'h1 ##1
    (i_ext_mode == 2'h1 && !i_download && !i_ext16_wr)[*2]
    |=> o_threshold_level == $past(i_ext16_val, 3))
    else $error("16-bit threshold not taken");
  a_ext8_take: assert property (
    i_ext8_wr && i_ext_mode == 2'h2 ##1
    (i_ext_mode == 2'h2 && !i_download && !i_ext8_wr)[*2]
    |=> o_threshold_level == {8'h00, $past(i_ext8_val, 3)})
    else $error("8-bit threshold not taken");
  a_rise_set: assert property (
    (o_active && i_act_mode == 4'h0 && i_on_dly_sel == 4'h0 &&
     i_brightness > o_threshold_level)[*5] |-> o_limit_obj)
    else $error("rising crossing not set");
  a_fall_set: assert property (
    (o_active && i_act_mode == 4'h2 && i_on_dly_sel == 4'h0 &&
     i_brightness < o_threshold_level)[*5] |-> o_limit_obj)
    else $error("falling crossing not set");
  a_silent_ret: assert property (
    i_act_mode == 4'h4 && o_tx_valid |-> o_tx_value)
    else $error("silenced state was sent");
  a_never_send: assert property (
    (i_cyc_sel == 7'h00 && !i_send_chg)[*3] |-> !o_tx_valid)
    else $error("telegram with sending off");
  a_tx_match: assert property (
    o_tx_valid |-> o_tx_value == o_limit_obj)
    else $error("telegram value differs");
  c_send_one: cover property (o_tx_valid && o_tx_value);
  c_send_zero: cover property (o_tx_valid && !o_tx_value);
  c_obj_rise: cover property ($rose(o_limit_obj));
endmodule
`default_nettype wire

// ===== testbench/blm_bus.sv
// bus partner: collects telegrams, writes external thresholds
// assumes telegram pulses last one cycle of i_core_clk
`timescale 1ns/1ps
`default_nettype none
module blm_bus (
  // clock
  input  wire logic        i_core_clk,
  // telegrams
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_value,
  // external threshold objects
  output var  logic        o_ext16_wr,
  output var  logic [15:0] o_ext16_val,
  output var  logic        o_ext8_wr,
  output var  logic [7:0]  o_ext8_val
);
  int   n_tel = 0;
  int   n_one = 0;
  logic last  = 1'b0;
  initial begin
    o_ext16_wr  = 1'b0;
    o_ext16_val = 16'h0000;
    o_ext8_wr   = 1'b0;
    o_ext8_val  = 8'h00;
  end
  always @(posedge i_core_clk) begin
    if (i_tx_valid === 1'b1) begin
      n_tel <= n_tel + 1;
      n_one <= n_one + (i_tx_value ? 1 : 0);
      last  <= i_tx_value;
    end
  end
  // value lines invert after the write so stale data never matches
  task automatic send16(input logic [15:0] v);
    @(posedge i_core_clk);
    o_ext16_wr  <= 1'b1;
    o_ext16_val <= v;
    @(posedge i_core_clk);
    o_ext16_wr  <= 1'b0;
    o_ext16_val <= ~v;
  endtask
  task automatic send8(input logic [7:0] v);
    @(posedge i_core_clk);
    o_ext8_wr  <= 1'b1;
    o_ext8_val <= v;
    @(posedge i_core_clk);
    o_ext8_wr  <= 1'b0;
    o_ext8_val <= ~v;
  endtask
endmodule
`default_nettype wire

// ===== testbench/brightness_limit_two_monitor_tb.sv
// bench for the second brightness limit monitor
// assumes blm_bus as bus side and blm_chk bound to the design
`timescale 1ns/1ps
`default_nettype none
module brightness_limit_two_monitor_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        chan = 1'b0, l1 = 1'b0, l2 = 1'b0, chg = 1'b0, dl = 1'b0;
  logic [15:0] b = 16'h0000;
  logic [4:0]  thr = 5'h00;
  logic [3:0]  hys = 4'h0, mode = 4'h0, ond = 4'h0, offd = 4'h0;
  logic [1:0]  xm = 2'h0;
  logic [6:0]  cyc = 7'h00;
  wire         w16, w8, obj, txv, txd, act;
  wire  [15:0] v16, lvl;
  wire  [7:0]  v8;
  int          fails = 0, num_checks = 0, tmo = 0;
  // ten clocks a second keeps delays short
  blm_monitor #(.P_CYC_PER_S(10)) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_chan_en(chan), .i_lim1_en(l1),
    .i_lim2_en(l2), .i_brightness(b), .i_thr_sel(thr), .i_hys_sel(hys),
    .i_act_mode(mode), .i_ext_mode(xm), .i_on_dly_sel(ond),
    .i_off_dly_sel(offd), .i_send_chg(chg), .i_cyc_sel(cyc),
    .i_download(dl), .i_ext16_wr(w16), .i_ext16_val(v16),
    .i_ext8_wr(w8), .i_ext8_val(v8), .o_limit_obj(obj), .o_tx_valid(txv),
    .o_tx_value(txd), .o_active(act), .o_threshold_level(lvl));
  blm_bus BUS (.i_core_clk(clk), .i_tx_valid(txv), .i_tx_value(txd),
    .o_ext16_wr(w16), .o_ext16_val(v16), .o_ext8_wr(w8), .o_ext8_val(v8));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    tmo++;
    if (tmo == 20000) begin
      fails++;
      conclude();
    end
  end
  // ----
  // helpers
  // ----
  task automatic conclude;
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // values are taken as they stood before the edge just passed
  task automatic chk(input string nm, input [15:0] got, input [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
    @(posedge clk);
  endtask
  // disabling clears state, so each scenario starts clean
  task automatic go(input [3:0] m, input [3:0] h, input [3:0] dn,
                    input c, input [6:0] cs, input [15:0] bv);
    chan <= 1'b0;
    cy(2);
    mode <= m;
    thr  <= 5'h04;
    hys  <= h;
    ond  <= dn;
    offd <= dn;
    chg  <= c;
    cyc  <= cs;
    b    <= bv;
    xm   <= 2'h0;
    l1   <= 1'b1;
    l2   <= 1'b1;
    @(posedge clk);
    chan <= 1'b1;
    cy(8);
  endtask
  task automatic t_thr;
    logic [4:0]  s[5] = '{5'h00, 5'h01, 5'h0A, 5'h15, 5'h1F};
    logic [15:0] e[5] = '{16'h0003, 16'h0005, 16'h0032, 16'h0069, 16'h0069};
    for (int i = 0; i < 5; i++) begin
      thr <= s[i];
      cy(4);
      chk("level", lvl, e[i]);
    end
    chan <= 1'b1;
    l1   <= 1'b1;
    l2   <= 1'b1;
    @(posedge clk);
    chk("active on", act, 1);
    l2 <= 1'b0;
    @(posedge clk);
    chk("active off", act, 0);
  endtask
  task automatic t_rise;
    int n0;
    go(4'h0, 4'h2, 4'h0, 1'b1, 7'h00, 16'h0000);
    n0 = BUS.n_tel;
    b <= 16'h0015;
    cy(6);
    chk("set", obj, 1);
    b <= 16'h0012;
    cy(6);
    chk("hold", obj, 1);
    b <= 16'h0011;
    cy(6);
    chk("clear", obj, 0);
    chk("tel", BUS.n_tel - n0, 2);
    go(4'h2, 4'h6, 4'h0, 1'b1, 7'h00, 16'h001E);
    chk("fall idle", obj, 0);
    b <= 16'h0013;
    cy(6);
    chk("fall set", obj, 1);
    b <= 16'h001E;
    cy(6);
    chk("fall hold", obj, 1);
    b <= 16'h001F;
    cy(6);
    chk("fall clear", obj, 0);
  endtask
  task automatic t_modes;
    int n0, p;
    for (int m = 0; m < 12; m++) begin
      go(4'(m), 4'h0, 4'h0, 1'b1, 7'h00, 16'h000A);
      n0 = BUS.n_tel;
      b <= 16'h001E;
      cy(6);
      p = m % 4;
      chk("mode obj", obj, p == 0 || p == 3);
      chk("mode tel", BUS.n_tel - n0, p < 2 ? m / 4 != 2 : m / 4 != 1);
    end
  endtask
  task automatic t_cyc;
    int n0, k;
    go(4'h0, 4'h0, 4'h0, 1'b0, 7'h01, 16'h001E);
    k = 0;
    while (txv !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    @(posedge clk);
    while (txv !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk("period", k >= 98 && k <= 101, 1);
    chk("cyc val", BUS.last, 1);
    n0 = BUS.n_tel;
    b <= 16'h0000;
    cy(8);
    chk("no chg", BUS.n_tel - n0, 0);
    go(4'h4, 4'h0, 4'h0, 1'b1, 7'h01, 16'h000A);
    n0 = BUS.n_tel;
    cy(250);
    chk("silent", BUS.n_tel - n0, 0);
  endtask
  task automatic t_dly;
    int z0, o0;
    go(4'h0, 4'h0, 4'h8, 1'b1, 7'h01, 16'h0000);
    o0 = BUS.n_one;
    b <= 16'h001E;
    cy(1700);
    chk("on wait", obj, 0);
    chk("old zero", BUS.n_one, o0);
    cy(150);
    chk("on done", obj, 1);
    z0 = BUS.n_tel - BUS.n_one;
    b <= 16'h0000;
    cy(1700);
    chk("off wait", obj, 1);
    chk("old one", BUS.n_tel - BUS.n_one, z0);
    cy(150);
    chk("off done", obj, 0);
  endtask
  task automatic t_ext;
    int n0;
    go(4'h0, 4'h0, 4'h0, 1'b0, 7'h00, 16'h0000);
    n0 = BUS.n_tel;
    b <= 16'h001E;
    cy(20);
    b <= 16'h0000;
    cy(20);
    chk("never", BUS.n_tel - n0, 0);
    xm <= 2'h1;
    BUS.send16(16'h0028);
    cy(4);
    chk("ext16", lvl, 16'h0028);
    dl <= 1'b1;
    @(posedge clk);
    dl <= 1'b0;
    cy(4);
    chk("download", lvl, 16'h0014);
    xm <= 2'h2;
    BUS.send8(8'h2D);
    cy(4);
    chk("ext8", lvl, 16'h002D);
    BUS.send16(16'h0050);
    cy(4);
    chk("wrong mode", lvl, 16'h002D);
  endtask
  initial begin
    cy(2);
    rst <= 1'b0;
    t_thr();
    t_rise();
    t_modes();
    t_cyc();
    t_dly();
    t_ext();
    conclude();
  end
endmodule
bind blm_monitor blm_chk CHK (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_chan_en(i_chan_en),
  .i_lim1_en(i_lim1_en), .i_lim2_en(i_lim2_en),
  .i_brightness(i_brightness), .i_thr_sel(i_thr_sel),
  .i_act_mode(i_act_mode), .i_ext_mode(i_ext_mode),
  .i_on_dly_sel(i_on_dly_sel), .i_send_chg(i_send_chg),
  .i_cyc_sel(i_cyc_sel), .i_download(i_download),
  .i_ext16_wr(i_ext16_wr), .i_ext16_val(i_ext16_val),
  .i_ext8_wr(i_ext8_wr), .i_ext8_val(i_ext8_val),
  .o_limit_obj(o_limit_obj), .o_tx_valid(o_tx_valid),
  .o_tx_value(o_tx_value), .o_active(o_active),
  .o_threshold_level(o_threshold_level));
`default_nettype wire
